/* verilog/bssc_top.sv */
// buffered synchronous serial channel: 32-byte buffer, pointers, serial engine
// assumes a classic wishbone master and inputs synchronous to CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module bssc_top (
  // system
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [17:0] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // serial link
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE_N,
  output logic             SO,
  input  wire logic        SI,
  input  wire logic        CS_N,
  // interrupt
  output logic             IRQ
);
  // ==========================================================
  // registers and state
  logic [7:0]  buf_mem [0:31];
  logic [4:0]  start_ptr_ff, end_ptr_ff, ptr_ff;
  logic [4:0]  ctrl_ff;
  logic        overrun_ff, wait_ff, abort_ff, so_ff, done_ff;
  logic [2:0]  rd_one_ff;
  logic [3:0]  irq_stat_ff, irq_mask_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  bssc_pkg::bssc_state_t state_ff;
  logic [6:0]  half_cnt_ff;
  logic        sclk_int_ff, sck_d_ff;
  logic [2:0]  bit_cnt_ff;
  logic [6:0]  rx_sh_ff;
  logic [5:0]  gap_cnt_ff;

  // ==========================================================
  // bus decode
  logic [15:0] idx;
  logic        acc, wr, rd, buf_hit, wr_lane, busy;
  assign idx     = ADR_I[17:2];
  assign acc     = CE && CYC_I && STB_I && !ack_ff;
  assign wr      = acc && WE_I;
  assign rd      = acc && !WE_I;
  assign wr_lane = SEL_I[0];
  assign buf_hit = (idx >= bssc_pkg::BSSC_IDX_BUF_FIRST) && (idx <= bssc_pkg::BSSC_IDX_BUF_LAST);
  assign busy    = (state_ff != bssc_pkg::BSSC_IDLE);

  // ==========================================================
  // serial clock selection and edges
  logic       ext_clk, running, tick, rise, fall;
  logic [6:0] half_sel;
  logic [1:0] gap_sel;
  logic [5:0] gap_len;
  assign ext_clk = (ctrl_ff[2:0] == bssc_pkg::BSSC_CKS_EXT);
  assign gap_sel = ctrl_ff[bssc_pkg::BSSC_CTRL_GAP_LSB +: 2];
  assign running = (state_ff == bssc_pkg::BSSC_SHIFT) || (state_ff == bssc_pkg::BSSC_GAP);

  // division select, code 7 is external
  always_comb begin
    case (ctrl_ff[2:0])
      3'h0:    half_sel = bssc_pkg::BSSC_HALF_DIV256;
      3'h1:    half_sel = bssc_pkg::BSSC_HALF_DIV64;
      3'h2:    half_sel = bssc_pkg::BSSC_HALF_DIV32;
      3'h3:    half_sel = bssc_pkg::BSSC_HALF_DIV16;
      3'h4:    half_sel = bssc_pkg::BSSC_HALF_DIV8;
      3'h5:    half_sel = bssc_pkg::BSSC_HALF_DIV4;
      3'h6:    half_sel = bssc_pkg::BSSC_HALF_DIV2;
      default: half_sel = bssc_pkg::BSSC_HALF_DIV2;
    endcase
  end

  // gap length per gap code
  always_comb begin
    case (gap_sel)
      2'h1:    gap_len = bssc_pkg::BSSC_GAP_8;
      2'h2:    gap_len = bssc_pkg::BSSC_GAP_24;
      2'h3:    gap_len = bssc_pkg::BSSC_GAP_56;
      default: gap_len = 6'h00;
    endcase
  end

  assign tick = running && (half_cnt_ff == 7'h00);
  assign rise = ext_clk ? (running && SCK_I && !sck_d_ff) : (tick && !sclk_int_ff);
  assign fall = ext_clk ? (running && !SCK_I && sck_d_ff) : (tick && sclk_int_ff);

  // internal divider restarts high at each start
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      half_cnt_ff <= 7'h00;
      sclk_int_ff <= 1'b1;
      sck_d_ff    <= 1'b1;
    end else if (CE) begin
      sck_d_ff <= SCK_I;
      if (!running) begin
        half_cnt_ff <= half_sel;
        sclk_int_ff <= 1'b1;
      end else if (half_cnt_ff == 7'h00) begin
        half_cnt_ff <= half_sel;
        sclk_int_ff <= !sclk_int_ff;
      end else begin
        half_cnt_ff <= half_cnt_ff - 7'h01;
      end
    end
  end

  // clock pin drives whenever an internal clock is chosen, toggling only while shifting
  assign SCK_OE_N = ext_clk;
  assign SCK_O    = (state_ff == bssc_pkg::BSSC_SHIFT) ? sclk_int_ff : 1'b1;

  // ==========================================================
  // transfer sequencer
  logic go_wr, byte_end, last_byte;
  assign go_wr     = wr && wr_lane && (idx == bssc_pkg::BSSC_IDX_STATUS) && DAT_I[bssc_pkg::BSSC_ST_GO];
  assign byte_end  = (state_ff == bssc_pkg::BSSC_SHIFT) && rise && (bit_cnt_ff == bssc_pkg::BSSC_LAST_BIT);
  assign last_byte = (ptr_ff == end_ptr_ff);

  // walks the buffer from start to end pointer
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_ff   <= bssc_pkg::BSSC_IDLE;
      ptr_ff     <= bssc_pkg::BSSC_PTR_RESET;
      bit_cnt_ff <= 3'h0;
      gap_cnt_ff <= 6'h00;
      rx_sh_ff   <= 7'h00;
      done_ff    <= 1'b0;
    end else if (CE) begin
      case (state_ff)
        bssc_pkg::BSSC_IDLE: begin
          if (go_wr) begin
            ptr_ff     <= start_ptr_ff;
            bit_cnt_ff <= 3'h0;
            done_ff    <= 1'b0;
            state_ff   <= CS_N ? bssc_pkg::BSSC_WAIT_CS : bssc_pkg::BSSC_SHIFT;
          end
        end
        bssc_pkg::BSSC_WAIT_CS: begin
          if (!CS_N)
            state_ff <= bssc_pkg::BSSC_SHIFT;
        end
        bssc_pkg::BSSC_SHIFT: begin
          if (CS_N) begin
            state_ff <= bssc_pkg::BSSC_IDLE; // abort on deselect
          end else if (rise) begin
            rx_sh_ff   <= {SI, rx_sh_ff[6:1]};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_end) begin
              if (last_byte) begin
                state_ff <= bssc_pkg::BSSC_IDLE;
                done_ff  <= 1'b1;
              end else begin
                ptr_ff     <= ptr_ff + 5'h01;
                gap_cnt_ff <= gap_len;
                if (gap_sel != 2'h0)
                  state_ff <= bssc_pkg::BSSC_GAP;
                else
                  state_ff <= bssc_pkg::BSSC_SHIFT;
              end
            end
          end
        end
        bssc_pkg::BSSC_GAP: begin
          if (CS_N)
            state_ff <= bssc_pkg::BSSC_IDLE;
          else if (rise && gap_cnt_ff == 6'h01)
            state_ff <= bssc_pkg::BSSC_SHIFT;
          else if (rise)
            gap_cnt_ff <= gap_cnt_ff - 6'h01;
        end
        default: state_ff <= bssc_pkg::BSSC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // buffer: bus access when idle, received bytes during shifting
  always_ff @(posedge CORE_CLK) begin
    if (CE) begin
      if (byte_end && !CS_N)
        buf_mem[ptr_ff] <= {SI, rx_sh_ff};
      else if (wr && wr_lane && buf_hit && !busy)
        buf_mem[idx[4:0]] <= DAT_I[7:0];
    end
  end

  // data out pin: shifter on falling edges, out level bit otherwise
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      so_ff <= 1'b0;
    end else if (CE) begin
      if (state_ff == bssc_pkg::BSSC_SHIFT && fall)
        so_ff <= buf_mem[ptr_ff][bit_cnt_ff];
      else if (wr && wr_lane && idx == bssc_pkg::BSSC_IDX_STATUS && !busy)
        so_ff <= DAT_I[bssc_pkg::BSSC_ST_OUT_LEVEL];
    end
  end
  assign SO = so_ff;

  // ==========================================================
  // pointers and control
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      start_ptr_ff <= bssc_pkg::BSSC_PTR_RESET;
      end_ptr_ff   <= bssc_pkg::BSSC_PTR_RESET;
      ctrl_ff      <= bssc_pkg::BSSC_CTRL_RESET;
      irq_mask_ff  <= bssc_pkg::BSSC_MASK_RESET;
    end else if (wr && wr_lane) begin
      if (idx == bssc_pkg::BSSC_IDX_START_PTR)
        start_ptr_ff <= DAT_I[4:0];
      if (idx == bssc_pkg::BSSC_IDX_END_PTR)
        end_ptr_ff <= DAT_I[4:0];
      if (idx == bssc_pkg::BSSC_IDX_CTRL)
        ctrl_ff <= DAT_I[4:0];
      if (idx == bssc_pkg::BSSC_IDX_IRQ_MASK)
        irq_mask_ff <= DAT_I[3:0];
    end
  end

  // ==========================================================
  // clear-only flags: set wins, zero write clears after a one was read
  logic st_rd, st_wr, set_ovr, set_wait, set_abt, clr_ovr, clr_wait, clr_abt;
  assign st_rd    = rd && idx == bssc_pkg::BSSC_IDX_STATUS;
  assign st_wr    = wr && wr_lane && idx == bssc_pkg::BSSC_IDX_STATUS;
  assign set_ovr  = CE && ext_clk && done_ff && !busy && !SCK_I && sck_d_ff;
  assign set_wait = acc && buf_hit && busy;
  assign set_abt  = CE && running && CS_N;
  assign clr_ovr  = st_wr && !DAT_I[bssc_pkg::BSSC_ST_OVERRUN] && rd_one_ff[2];
  assign clr_wait = st_wr && !DAT_I[bssc_pkg::BSSC_ST_WAIT] && rd_one_ff[1];
  assign clr_abt  = st_wr && !DAT_I[bssc_pkg::BSSC_ST_ABORT] && rd_one_ff[0];

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      overrun_ff <= 1'b0;
      wait_ff    <= 1'b0;
      abort_ff   <= 1'b0;
      rd_one_ff  <= 3'h0;
    end else begin
      overrun_ff <= set_ovr || (overrun_ff && !clr_ovr);
      wait_ff    <= set_wait || (wait_ff && !clr_wait);
      abort_ff   <= set_abt || (abort_ff && !clr_abt);
      if (st_rd)
        rd_one_ff <= {overrun_ff, wait_ff, abort_ff};
      else if (st_wr)
        rd_one_ff <= 3'h0;
    end
  end

  // ==========================================================
  // interrupt: sticky events cleared by reading, masked onto IRQ
  logic [3:0] irq_set;
  assign irq_set = {set_ovr, set_wait, set_abt, byte_end && last_byte && !CS_N};
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N)
      irq_stat_ff <= 4'h0;
    else if (rd && idx == bssc_pkg::BSSC_IDX_IRQ_STAT)
      irq_stat_ff <= irq_set;
    else
      irq_stat_ff <= irq_stat_ff | irq_set;
  end
  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================
  // read mux and acknowledge, one wait state
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (buf_hit)
      rd_byte = busy ? 8'h00 : buf_mem[idx[4:0]];
    else if (idx == bssc_pkg::BSSC_IDX_START_PTR)
      rd_byte = {bssc_pkg::BSSC_UPPER_ONES, start_ptr_ff};
    else if (idx == bssc_pkg::BSSC_IDX_END_PTR)
      rd_byte = {bssc_pkg::BSSC_UPPER_ONES, end_ptr_ff};
    else if (idx == bssc_pkg::BSSC_IDX_CTRL)
      rd_byte = {bssc_pkg::BSSC_UPPER_ONES, ctrl_ff};
    else if (idx == bssc_pkg::BSSC_IDX_STATUS)
      rd_byte = {bssc_pkg::BSSC_UPPER_ONES, so_ff, overrun_ff, wait_ff, abort_ff, busy};
    else if (idx == bssc_pkg::BSSC_IDX_IRQ_STAT)
      rd_byte = {4'h0, irq_stat_ff};
    else if (idx == bssc_pkg::BSSC_IDX_IRQ_MASK)
      rd_byte = {4'h0, irq_mask_ff};
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else if (CE) begin
      ack_ff <= CYC_I && STB_I && !ack_ff;
      if (rd)
        dat_ff <= {24'h000000, rd_byte};
    end else begin
      ack_ff <= 1'b0;
    end
  end
  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;

  // ==========================================================
  // checks
  property p_div_sel;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (ctrl_ff[2:0] == 3'h6) |-> (half_sel == 7'h00) && !SCK_OE_N;
  endproperty
  a_div_sel: assert property (p_div_sel) else $error("div2 code not selected");

  property p_ext_input;
    @(posedge CORE_CLK) disable iff (!RESET_N) ext_clk |-> SCK_OE_N;
  endproperty
  a_ext_input: assert property (p_ext_input) else $error("clock pin driven in ext mode");

  property p_no_gap;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (CE && byte_end && !last_byte && !CS_N && gap_sel == 2'h0) |=> (state_ff == bssc_pkg::BSSC_SHIFT);
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap inserted with gap code zero");

  property p_gap_len;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (CE && byte_end && !last_byte && !CS_N && gap_sel == 2'h2) |=>
        (state_ff == bssc_pkg::BSSC_GAP) && (gap_cnt_ff == 6'h18);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap length not 24");

  property p_wait_set;
    @(posedge CORE_CLK) disable iff (!RESET_N) (acc && buf_hit && busy) |=> wait_ff;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait flag not set");

  property p_overrun;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (CE && ext_clk && done_ff && !busy && !SCK_I && sck_d_ff) |=> overrun_ff;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");

  property p_ovr_clear;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (overrun_ff && !set_ovr && !(st_wr && rd_one_ff[2] && !DAT_I[3])) |=> overrun_ff;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun lost without clear");

  property p_one_keeps;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (abort_ff && st_wr && DAT_I[1]) |=> abort_ff;
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("one write cleared a flag");

  property p_level;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      (st_wr && !busy && CE) |=> (SO == $past(DAT_I[4]));
  endproperty
  a_level: assert property (p_level) else $error("out level not driven");

  property p_go;
    @(posedge CORE_CLK) disable iff (!RESET_N) (go_wr && !busy) |=> busy;
  endproperty
  a_go: assert property (p_go) else $error("go did not start a transfer");
endmodule // bssc_top
`default_nettype wire

/* verilog/bssc_pkg.sv */
// package for the buffered synchronous serial channel
// assumes a 32-bit classic wishbone bus with registers in the low byte lane
package bssc_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [15:0] BSSC_IDX_BUF_FIRST = 16'hFF80;
  localparam logic [15:0] BSSC_IDX_BUF_LAST  = 16'hFF9F;
  localparam logic [15:0] BSSC_IDX_START_PTR = 16'hFFA4;
  localparam logic [15:0] BSSC_IDX_END_PTR   = 16'hFFA5;
  localparam logic [15:0] BSSC_IDX_CTRL      = 16'hFFA6;
  localparam logic [15:0] BSSC_IDX_STATUS    = 16'hFFA7;
  localparam logic [15:0] BSSC_IDX_IRQ_STAT  = 16'hFFA8;
  localparam logic [15:0] BSSC_IDX_IRQ_MASK  = 16'hFFA9;
  // ==========================================================
  // field positions
  localparam int BSSC_CTRL_GAP_LSB = 3;
  localparam int BSSC_ST_OUT_LEVEL = 4;
  localparam int BSSC_ST_OVERRUN   = 3;
  localparam int BSSC_ST_WAIT      = 2;
  localparam int BSSC_ST_ABORT     = 1;
  localparam int BSSC_ST_GO        = 0;
  localparam int BSSC_IRQ_DONE     = 0;
  localparam int BSSC_IRQ_ABORT    = 1;
  localparam int BSSC_IRQ_WAIT     = 2;
  localparam int BSSC_IRQ_OVERRUN  = 3;
  // ==========================================================
  // reset values and fixed bits
  localparam logic [2:0] BSSC_UPPER_ONES  = 3'h7;
  localparam logic [4:0] BSSC_PTR_RESET   = 5'h00;
  localparam logic [4:0] BSSC_CTRL_RESET  = 5'h00;
  localparam logic [3:0] BSSC_MASK_RESET  = 4'h0;
  localparam logic [2:0] BSSC_CKS_EXT     = 3'h7;
  // ==========================================================
  // half periods of the serial clock in system clocks, less one, per clock code
  localparam logic [6:0] BSSC_HALF_DIV256 = 7'h7F;
  localparam logic [6:0] BSSC_HALF_DIV64  = 7'h1F;
  localparam logic [6:0] BSSC_HALF_DIV32  = 7'h0F;
  localparam logic [6:0] BSSC_HALF_DIV16  = 7'h07;
  localparam logic [6:0] BSSC_HALF_DIV8   = 7'h03;
  localparam logic [6:0] BSSC_HALF_DIV4   = 7'h01;
  localparam logic [6:0] BSSC_HALF_DIV2   = 7'h00;
  // gap lengths in serial clock cycles, and the index of the last bit of a byte
  localparam logic [5:0] BSSC_GAP_8       = 6'h08;
  localparam logic [5:0] BSSC_GAP_24      = 6'h18;
  localparam logic [5:0] BSSC_GAP_56      = 6'h38;
  localparam logic [2:0] BSSC_LAST_BIT    = 3'h7;
  // ==========================================================
  // transfer states, gray along idle, wait, shift, gap
  typedef enum logic [1:0] {
    BSSC_IDLE    = 2'b00,
    BSSC_WAIT_CS = 2'b01,
    BSSC_SHIFT   = 2'b11,
    BSSC_GAP     = 2'b10
  } bssc_state_t;
endpackage

/* verif/bssc_peer.sv */
// external serial peer: chip select, data in and out, optional external clock
// assumes the bench resolves the clock line from the device output enable
`timescale 1ns/1ps
`default_nettype none
module bssc_peer (
  // bench control
  input  wire logic       clk,
  input  wire logic       cs_on,
  input  wire logic [7:0] tx_byte,
  // serial lines
  input  wire logic       sck_line,
  input  wire logic       so,
  output logic            cs_n,
  output logic            si,
  output logic            ext_sck,
  output logic [7:0]      rx_byte
);
  logic [2:0] bit_n;
  logic       last_si;
  // idle state at time zero, external clock idles high
  initial begin
    ext_sck = 1'b1;
    bit_n   = 3'h0;
    last_si = 1'b0;
    rx_byte = 8'h00;
  end
  // deselected data line shows the inverse of the last bit
  assign cs_n = ~cs_on;
  assign si   = cs_on ? last_si : ~last_si;
  // bit counter restarts on deselect
  always @(posedge cs_n) bit_n = 3'h0;
  // data out on falls, lsb first
  always @(negedge sck_line) begin
    if (cs_on) begin
      last_si = tx_byte[bit_n];
      bit_n   = bit_n + 3'h1;
    end
  end
  // capture device data on rises
  always @(posedge sck_line) if (cs_on) rx_byte = {so, rx_byte[7:1]};
  // external clock pulses, two system clocks per phase
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk);
      ext_sck <= 1'b0;
      repeat (2) @(posedge clk);
      ext_sck <= 1'b1;
    end
  endtask
endmodule // bssc_peer
`default_nettype wire

/* verif/bssc_top_tb.sv */
// bench for the buffered serial channel: wishbone tasks and directed tests
// assumes bssc_pkg, bssc_top and bssc_peer compiled first
`timescale 1ns/1ps
`default_nettype none
module bssc_top_tb;
  logic        clk, rst_n, cyc, stb, we, clr, cs_on, line_q;
  logic [17:0] adr;
  logic [31:0] dat_w, dat_r;
  logic        ack, sck_o, sck_oe_n, so, si, cs_n, irq, ext_sck, line;
  logic [7:0]  rx_byte, q;
  int          error_cnt, n_compared, tcyc, t_first, t_r1, t_last, nrise, nfall, span0;
  // clock line: device drives it unless external clock is chosen
  assign line = sck_oe_n ? ext_sck : sck_o;
  bssc_top dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .CE(1'b1), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .SCK_I(line), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .SO(so), .SI(si), .CS_N(cs_n),
    .IRQ(irq));
  bssc_peer peer_u (.clk(clk), .cs_on(cs_on), .tx_byte(8'hA5), .sck_line(line), .so(so),
    .cs_n(cs_n), .si(si), .ext_sck(ext_sck), .rx_byte(rx_byte));
  // clock generator, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // serial clock edge timing in system clocks
  always @(posedge clk) begin
    tcyc   <= tcyc + 1;
    line_q <= line;
    if (clr) begin
      nrise <= 0;
      nfall <= 0;
    end else if (line_q && !line) begin
      nfall <= nfall + 1;
      if (nfall == 0) t_first <= tcyc;
    end else if (!line_q && line) begin
      nrise  <= nrise + 1;
      t_last <= tcyc;
      if (nrise == 0) t_r1 <= tcyc;
    end
  end
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'h0};
    dat_w <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      chk("ack", 32'h1, 32'h0);
      close_out();
    end
  endtask
  task automatic rdc(input string nm, input logic [15:0] i, input logic [7:0] m, e);
    wb(1'b0, i, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q & m});
  endtask
  // start a transfer and poll the go flag down
  task automatic xfer();
    int i;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h01);
    for (i = 0; i < 1500; i++) begin
      wb(1'b0, bssc_pkg::BSSC_IDX_STATUS, 8'h00);
      if (q[0] === 1'b0) break;
    end
    if (i == 1500) begin
      chk("go_clear", 32'h0, 32'h1);
      close_out();
    end
  endtask
  // main sequence
  initial begin
    int dv[7];
    dv = '{256, 64, 32, 16, 8, 4, 2};
    {rst_n, cyc, stb, we, clr, cs_on, line_q} = 7'h01;
    adr = 18'h00000;
    dat_w = 32'h0;
    {error_cnt, n_compared, tcyc, t_first, t_r1, t_last, nrise, nfall} = '0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", bssc_pkg::BSSC_IDX_CTRL, 8'hFF, 8'hE0);
    rdc("end_ptr", bssc_pkg::BSSC_IDX_END_PTR, 8'hFF, 8'hE0);
    rdc("start_ptr", bssc_pkg::BSSC_IDX_START_PTR, 8'hFF, 8'hE0);
    rdc("status", bssc_pkg::BSSC_IDX_STATUS, 8'hFF, 8'hE0);
    rdc("unmapped", 16'hFFB0, 8'hFF, 8'h00);
    wb(1'b1, bssc_pkg::BSSC_IDX_END_PTR, 8'h1F);
    rdc("end_ptr_w", bssc_pkg::BSSC_IDX_END_PTR, 8'hFF, 8'hFF);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h10);
    chk("so_high", 32'h1, {31'h0, so});
    rdc("out_level", bssc_pkg::BSSC_IDX_STATUS, 8'h10, 8'h10);
    $display("test registers done");
    // two bytes, fastest clock, transfer held waiting for chip select
    wb(1'b1, 16'hFF80, 8'h3C);
    wb(1'b1, 16'hFF81, 8'hC3);
    wb(1'b1, bssc_pkg::BSSC_IDX_START_PTR, 8'h00);
    wb(1'b1, bssc_pkg::BSSC_IDX_END_PTR, 8'h01);
    wb(1'b1, bssc_pkg::BSSC_IDX_CTRL, 8'h06);
    wb(1'b1, bssc_pkg::BSSC_IDX_IRQ_MASK, 8'h01);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h01);
    rdc("go_cs_wait", bssc_pkg::BSSC_IDX_STATUS, 8'h01, 8'h01);
    rdc("buf_busy", 16'hFF80, 8'hFF, 8'h00);
    rdc("wait_set", bssc_pkg::BSSC_IDX_STATUS, 8'h04, 8'h04);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h04);
    rdc("wait_one_w", bssc_pkg::BSSC_IDX_STATUS, 8'h04, 8'h04);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h00);
    rdc("wait_clr", bssc_pkg::BSSC_IDX_STATUS, 8'h04, 8'h00);
    cs_on <= 1'b1;
    xfer();
    span0 = t_last - t_first;
    chk("rises_inter_byte_gap_sel_lo", 32'd16, nrise);
    chk("peer_rx", 32'hC3, {24'h0, rx_byte});
    chk("irq_done", 32'h1, {31'h0, irq});
    rdc("irq_stat", bssc_pkg::BSSC_IDX_IRQ_STAT, 8'hFF, 8'h05);
    @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rdc("buf_rx", 16'hFF81, 8'hFF, 8'hA5);
    $display("test transfer done");
    // gap codes stretch the span by whole serial periods
    wb(1'b1, bssc_pkg::BSSC_IDX_IRQ_MASK, 8'h00);
    for (int g = 1; g < 4; g++) begin
      wb(1'b1, bssc_pkg::BSSC_IDX_CTRL, {3'h0, 2'(g), 3'h6});
      xfer();
      chk("rises_gap", 32'd16, nrise);
      chk("gap_span", (g == 1 ? 8 : g == 2 ? 24 : 56) * 2, t_last - t_first - span0);
    end
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc("irq_sticky", bssc_pkg::BSSC_IDX_IRQ_STAT, 8'hFF, 8'h01);
    $display("test gaps done");
    // each internal clock code: half period and pin direction
    wb(1'b1, bssc_pkg::BSSC_IDX_END_PTR, 8'h00);
    for (int c = 0; c < 7; c++) begin
      wb(1'b1, bssc_pkg::BSSC_IDX_CTRL, {5'h00, 3'(c)});
      chk("sck_oe_int", 32'h0, {31'h0, sck_oe_n});
      xfer();
      chk("half_period", dv[c] / 2, t_r1 - t_first);
    end
    $display("test clock codes done");
    // external clock, extra pulse after completion
    wb(1'b1, bssc_pkg::BSSC_IDX_CTRL, 8'h07);
    chk("sck_oe_ext", 32'h1, {31'h0, sck_oe_n});
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h01);
    peer_u.pulse(8);
    rdc("go_ext_done", bssc_pkg::BSSC_IDX_STATUS, 8'h01, 8'h00);
    rdc("ovr_none", bssc_pkg::BSSC_IDX_STATUS, 8'h08, 8'h00);
    peer_u.pulse(1);
    rdc("ovr_set", bssc_pkg::BSSC_IDX_STATUS, 8'h08, 8'h08);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h08);
    rdc("ovr_one_w", bssc_pkg::BSSC_IDX_STATUS, 8'h08, 8'h08);
    wb(1'b1, bssc_pkg::BSSC_IDX_STATUS, 8'h00);
    rdc("ovr_clr", bssc_pkg::BSSC_IDX_STATUS, 8'h08, 8'h00);
    $display("test overrun done");
    close_out();
  end
endmodule // bssc_top_tb
`default_nettype wire
